// ==== pkg/therm_pkg.sv ====
package therm_pkg;

   // Contract
   // - high threshold command stores/returns two bytes
   // - low threshold command stores/returns two bytes
   // - thresholds travel MSB first, temperature encoding
   // - config write loads one following byte
   // - config read returns one byte
   // - read temperature returns latest result, two bytes
   // - read counter returns one byte, read only
   // - read slope returns one byte, read only
   // - start command begins conversion, no data
   // - single mode: one conversion then idle
   // - continuous mode: convert until stopped
   // - stop: finish current conversion, then idle
   // - master restarts each single-mode conversion
   // - master waits nonvolatile time between writes
   // - slave acks address, command, every written byte
   // - master chains commands with repeated start; the code ends each command with a stop
   // - config 02h: active high, continuous
   // - single select bit chooses one-shot conversion
   // - polarity bit sets thermostat output level
   // - respond only to 1001 plus select pins
   // - read: command, repeated start, read address

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int SCL_HZ = 100_000;
   localparam int QUARTER_CYCLES = CLK_HZ / (4 * SCL_HZ);
   localparam int NV_WRITE_MS = 10;
   localparam int NV_WRITE_CYCLES = NV_WRITE_MS * (CLK_HZ / 1000);

   // ----------------------------------------
   // bus codes and commands
   // ----------------------------------------
   localparam logic [3:0] CONTROL_CODE = 4'h9;
   localparam logic [7:0] CMD_READ_TEMP = 8'haa;
   localparam logic [7:0] CMD_HIGH = 8'ha1;
   localparam logic [7:0] CMD_LOW = 8'ha2;
   localparam logic [7:0] CMD_CONFIG = 8'hac;
   localparam logic [7:0] CMD_COUNT = 8'ha8;
   localparam logic [7:0] CMD_SLOPE = 8'ha9;
   localparam logic [7:0] CMD_START = 8'hee;
   localparam logic [7:0] CMD_STOP = 8'h22;
   localparam logic [7:0] IDLE_BYTE = 8'hff;

   // ----------------------------------------
   // configuration byte and reset values
   // ----------------------------------------
   localparam int CFG_SINGLE_BIT = 0;
   localparam int CFG_POL_BIT = 1;
   localparam int CFG_NVB_BIT = 4;
   localparam int CFG_DONE_BIT = 7;
   localparam logic CFG_SINGLE_RESET = 1'b0;
   localparam logic CFG_POL_RESET = 1'b0;
   localparam logic [15:0] HIGH_RESET = 16'h0000;
   localparam logic [15:0] LOW_RESET = 16'h0000;

   // ----------------------------------------
   // controller registers
   // ----------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_WDATA = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_RDATA = 4'hc;
   localparam int CTRL_CMD_LSB = 0;
   localparam int CTRL_GO_BIT = 8;
   localparam int CTRL_WLEN_LSB = 9;
   localparam int CTRL_RLEN_LSB = 11;
   localparam int CTRL_SEL_LSB = 13;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_NACK_BIT = 1;
   localparam int STAT_HOLD_BIT = 2;

   typedef enum logic [4:0] {
      SL_IDLE = 5'b00001,
      SL_RECV = 5'b00010,
      SL_ACK = 5'b00100,
      SL_SEND = 5'b01000,
      SL_MACK = 5'b10000
   } slave_state_e;

   typedef enum logic [4:0] {
      HM_IDLE = 5'b00001,
      HM_HOLD = 5'b00010,
      HM_START = 5'b00100,
      HM_BYTE = 5'b01000,
      HM_STOP = 5'b10000
   } host_state_e;

endpackage

// ==== pkg/therm_link_if.sv ====
`timescale 1ns/1ps
interface therm_link_if;
   logic m_scl_out;
   logic m_scl_oe;
   logic m_sda_out;
   logic m_sda_oe;
   logic s_sda_out;
   logic s_sda_oe;
   logic scl;
   logic sda;

   // open drain: any enabled low driver pulls the wire down
   assign scl = ~(m_scl_oe & ~m_scl_out);
   assign sda = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));

   modport master (output m_scl_out, m_scl_oe, m_sda_out, m_sda_oe, input scl, sda);
   modport slave (output s_sda_out, s_sda_oe, input scl, sda);
endinterface

// ==== core/therm_slave.sv ====
`timescale 1ns/1ps
module therm_slave
   import therm_pkg::*;
#(
   parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
   input logic ref_clk_in,
   input logic rst_in,
   therm_link_if.slave link,
   input logic [2:0] addr_sel_in,
   input logic [15:0] temperature_in,
   input logic [7:0] count_remaining_in,
   input logic [7:0] slope_in,
   input logic conv_done_in,
   input logic alarm_in,
   output logic conv_start_out,
   output logic converting_out,
   output logic [15:0] high_threshold_out,
   output logic [15:0] low_threshold_out,
   output logic single_conversion_select_out,
   output logic output_polarity_out,
   output logic nonvolatile_busy_out,
   output logic thermostat_output_out
);

   localparam int NVW = $clog2(NV_CYCLES + 1);

   // ----------------------------------------
   // state
   // ----------------------------------------
   slave_state_e state_q;
   logic scl_q;
   logic sda_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] sh_q;
   logic first_q;
   logic rw_q;
   logic [7:0] cmd_q;
   logic [1:0] idx_q;
   logic [7:0] hold_q;
   logic sda_oe_q;
   logic [15:0] high_q;
   logic [15:0] low_q;
   logic single_q;
   logic pol_q;
   logic conv_q;
   logic stop_pend_q;
   logic done_q;
   logic start_pulse_q;
   logic [NVW-1:0] nv_cnt_q;
   logic nv_busy_q;
   logic therm_q;
   logic [7:0] cfg_rd;

   // ----------------------------------------
   // line events
   // ----------------------------------------
   wire scl_rise = link.scl & ~scl_q;
   wire scl_fall = ~link.scl & scl_q;
   wire start_seen = scl_q & link.scl & sda_q & ~link.sda;
   wire stop_seen = scl_q & link.scl & ~sda_q & link.sda;
   wire addr_match = sh_q[7:1] == {CONTROL_CODE, addr_sel_in};
   wire byte_done = (state_q == SL_RECV) & scl_fall & (bit_cnt_q == 4'd8);
   wire [1:0] idx_nxt = (idx_q == 2'd3) ? idx_q : idx_q + 2'd1;

   // ----------------------------------------
   // write decode
   // ----------------------------------------
   wire wr_data = byte_done & ~first_q & ~rw_q;
   wire cmd_byte = wr_data & (idx_q == 2'd0);
   wire cmd_start = cmd_byte & (sh_q == CMD_START);
   wire cmd_stop = cmd_byte & (sh_q == CMD_STOP);
   wire wr_first = wr_data & (idx_q == 2'd1);
   wire wr_second = wr_data & (idx_q == 2'd2);
   // only the write-capable commands take data; all others drop it
   wire wr_cfg = wr_first & (cmd_q == CMD_CONFIG);
   wire wr_high = wr_second & (cmd_q == CMD_HIGH);
   wire wr_low = wr_second & (cmd_q == CMD_LOW);
   wire wr_hold = wr_first & ((cmd_q == CMD_HIGH) | (cmd_q == CMD_LOW));
   wire nv_write = wr_cfg | wr_high | wr_low;

   // ----------------------------------------
   // read selection
   // ----------------------------------------
   always_comb begin
      cfg_rd = 8'h00;
      cfg_rd[CFG_SINGLE_BIT] = single_q;
      cfg_rd[CFG_POL_BIT] = pol_q;
      cfg_rd[CFG_NVB_BIT] = nv_busy_q;
      cfg_rd[CFG_DONE_BIT] = done_q;
   end

   wire is_two = (cmd_q == CMD_READ_TEMP) | (cmd_q == CMD_HIGH) | (cmd_q == CMD_LOW);
   wire [15:0] word_rd = (cmd_q == CMD_READ_TEMP) ? temperature_in :
                         (cmd_q == CMD_HIGH) ? high_q : low_q;
   wire [7:0] byte_rd = (cmd_q == CMD_CONFIG) ? cfg_rd :
                        (cmd_q == CMD_COUNT) ? count_remaining_in :
                        (cmd_q == CMD_SLOPE) ? slope_in : IDLE_BYTE;
   // most significant byte goes out first
   wire [7:0] tx_byte = is_two ? ((idx_q == 2'd0) ? word_rd[15:8] :
                                  (idx_q == 2'd1) ? word_rd[7:0] : IDLE_BYTE) :
                        ((idx_q == 2'd0) ? byte_rd : IDLE_BYTE);

   // ----------------------------------------
   // two-wire slave engine
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= link.scl;
         sda_q <= link.sda;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= SL_IDLE;
         bit_cnt_q <= 4'h0;
         sh_q <= 8'h00;
         first_q <= 1'b0;
         rw_q <= 1'b0;
         cmd_q <= 8'h00;
         idx_q <= 2'd0;
         sda_oe_q <= 1'b0;
      end else if (start_seen) begin
         state_q <= SL_RECV;
         bit_cnt_q <= 4'h0;
         first_q <= 1'b1;
         idx_q <= 2'd0;
         sda_oe_q <= 1'b0;
      end else if (stop_seen) begin
         state_q <= SL_IDLE;
         sda_oe_q <= 1'b0;
      end else begin
         unique case (state_q)
            SL_IDLE: begin
               sda_oe_q <= 1'b0;
            end
            SL_RECV: begin
               if (scl_rise) begin
                  sh_q <= {sh_q[6:0], link.sda};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (byte_done) begin
                  first_q <= 1'b0;
                  if (first_q) begin
                     rw_q <= sh_q[0];
                  end else begin
                     idx_q <= idx_nxt;
                  end
                  if (cmd_byte) begin
                     cmd_q <= sh_q;
                  end
                  if (first_q && !addr_match) begin
                     state_q <= SL_IDLE;
                  end else begin
                     state_q <= SL_ACK;
                     sda_oe_q <= 1'b1;
                  end
               end
            end
            SL_ACK: begin
               if (scl_fall) begin
                  bit_cnt_q <= 4'h0;
                  if (rw_q) begin
                     state_q <= SL_SEND;
                     sh_q <= tx_byte;
                     sda_oe_q <= ~tx_byte[7];
                  end else begin
                     state_q <= SL_RECV;
                     sda_oe_q <= 1'b0;
                  end
               end
            end
            SL_SEND: begin
               if (scl_fall) begin
                  if (bit_cnt_q == 4'd7) begin
                     state_q <= SL_MACK;
                     sda_oe_q <= 1'b0;
                     idx_q <= idx_nxt;
                  end else begin
                     sh_q <= {sh_q[6:0], 1'b0};
                     sda_oe_q <= ~sh_q[6];
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end
               end
            end
            SL_MACK: begin
               // master ack: send next byte; no ack: release until stop
               if (scl_rise) begin
                  state_q <= link.sda ? SL_IDLE : SL_ACK;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // stored values
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         hold_q <= 8'h00;
         high_q <= HIGH_RESET;
         low_q <= LOW_RESET;
         single_q <= CFG_SINGLE_RESET;
         pol_q <= CFG_POL_RESET;
      end else begin
         if (wr_hold) begin
            hold_q <= sh_q;
         end
         if (wr_high) begin
            high_q <= {hold_q, sh_q};
         end
         if (wr_low) begin
            low_q <= {hold_q, sh_q};
         end
         if (wr_cfg) begin
            single_q <= sh_q[CFG_SINGLE_BIT];
            pol_q <= sh_q[CFG_POL_BIT];
         end
      end
   end

   // ----------------------------------------
   // conversion control
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         conv_q <= 1'b0;
         stop_pend_q <= 1'b0;
         done_q <= 1'b0;
         start_pulse_q <= 1'b0;
      end else begin
         done_q <= (done_q & ~cmd_start) | (conv_done_in & conv_q);
         if (cmd_start) begin
            conv_q <= 1'b1;
            stop_pend_q <= 1'b0;
            start_pulse_q <= ~conv_q;
         end else if (conv_done_in && conv_q) begin
            if (single_q || stop_pend_q) begin
               conv_q <= 1'b0;
               stop_pend_q <= 1'b0;
               start_pulse_q <= 1'b0;
            end else begin
               start_pulse_q <= 1'b1;
               stop_pend_q <= cmd_stop;
            end
         end else begin
            start_pulse_q <= 1'b0;
            if (cmd_stop && conv_q) begin
               stop_pend_q <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // nonvolatile busy and thermostat pin
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         nv_cnt_q <= '0;
         nv_busy_q <= 1'b0;
         therm_q <= 1'b0;
      end else begin
         if (nv_write) begin
            nv_cnt_q <= NVW'(NV_CYCLES);
         end else if (nv_cnt_q != '0) begin
            nv_cnt_q <= nv_cnt_q - NVW'(1);
         end
         nv_busy_q <= nv_write | (nv_cnt_q > NVW'(1));
         therm_q <= pol_q ? alarm_in : ~alarm_in;
      end
   end

   assign link.s_sda_out = 1'b0;
   assign link.s_sda_oe = sda_oe_q;
   assign conv_start_out = start_pulse_q;
   assign converting_out = conv_q;
   assign high_threshold_out = high_q;
   assign low_threshold_out = low_q;
   assign single_conversion_select_out = single_q;
   assign output_polarity_out = pol_q;
   assign nonvolatile_busy_out = nv_busy_q;
   assign thermostat_output_out = therm_q;

endmodule // therm_slave

// ==== core/therm_master.sv ====
`timescale 1ns/1ps
module therm_master
   import therm_pkg::*;
#(
   parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
   input logic ref_clk_in,
   input logic rst_in,
   input logic wb_cyc_in,
   input logic wb_stb_in,
   input logic wb_we_in,
   input logic [3:0] wb_adr_in,
   input logic [3:0] wb_sel_in,
   input logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   therm_link_if.master link
);

   localparam int QW = $clog2(QUARTER_CYCLES);
   localparam int NVW = $clog2(NV_CYCLES + 1);

   host_state_e state_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic [15:0] ctrl_q;
   logic [15:0] wdata_q;
   logic [15:0] rdata_q;
   logic nack_q;
   logic [QW-1:0] q_cnt_q;
   logic [1:0] phase_q;
   logic [3:0] bitn_q;
   logic [7:0] sh_q;
   logic ackbit_q;
   logic rd_phase_q;
   logic [1:0] cnt_q;
   logic scl_oe_q;
   logic sda_oe_q;
   logic [NVW-1:0] nv_q;

   // ----------------------------------------
   // register decode
   // ----------------------------------------
   wire busy = state_q != HM_IDLE;
   wire hit = wb_cyc_in & wb_stb_in & ~ack_q;
   wire wr = hit & wb_we_in & ~busy;
   wire [31:0] mask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
   wire [15:0] ctrl_new = (ctrl_q & ~mask[15:0]) | (wb_dat_in[15:0] & mask[15:0]);
   wire [15:0] wdata_new = (wdata_q & ~mask[15:0]) | (wb_dat_in[15:0] & mask[15:0]);
   wire go = wr & (wb_adr_in == REG_CTRL) & mask[CTRL_GO_BIT] & wb_dat_in[CTRL_GO_BIT];
   wire [31:0] stat_word = (32'(busy) << STAT_BUSY_BIT) | (32'(nack_q) << STAT_NACK_BIT) |
                           (32'(state_q == HM_HOLD) << STAT_HOLD_BIT);
   wire [31:0] rd_word = (wb_adr_in == REG_CTRL) ? {16'h0000, ctrl_q} :
                         (wb_adr_in == REG_WDATA) ? {16'h0000, wdata_q} :
                         (wb_adr_in == REG_STATUS) ? stat_word :
                         (wb_adr_in == REG_RDATA) ? {16'h0000, rdata_q} : 32'h0000_0000;

   // ----------------------------------------
   // transfer decode
   // ----------------------------------------
   wire [7:0] cmd = ctrl_q[CTRL_CMD_LSB +: 8];
   wire [1:0] wlen = ctrl_q[CTRL_WLEN_LSB +: 2];
   wire [1:0] rlen = ctrl_q[CTRL_RLEN_LSB +: 2];
   wire [2:0] sel = ctrl_q[CTRL_SEL_LSB +: 3];
   wire tick = q_cnt_q == QW'(QUARTER_CYCLES - 1);
   wire is_rx = rd_phase_q & (cnt_q != 2'd0);
   wire last_rx = cnt_q == rlen;
   wire [7:0] addr_byte = {CONTROL_CODE, sel, rd_phase_q};
   // threshold words leave most significant byte first
   wire [7:0] next_tx = (cnt_q == 2'd0) ? cmd : (cnt_q == 2'd1) ? wdata_q[15:8] : wdata_q[7:0];
   wire more_tx = 3'(cnt_q) < (3'(wlen) + 3'd1);
   wire [1:0] cnt_inc = cnt_q + 2'd1;
   wire stop_end = (state_q == HM_STOP) & tick & (phase_q == 2'd3);

   // ----------------------------------------
   // register slave
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
         ctrl_q <= 16'h0000;
         wdata_q <= 16'h0000;
      end else begin
         ack_q <= hit;
         if (hit) begin
            dat_q <= rd_word;
         end
         if (wr && wb_adr_in == REG_CTRL) begin
            ctrl_q <= ctrl_new & ~(16'h0001 << CTRL_GO_BIT);
         end
         if (wr && wb_adr_in == REG_WDATA) begin
            wdata_q <= wdata_new;
         end
      end
   end

   // ----------------------------------------
   // nonvolatile write spacing
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         nv_q <= '0;
      end else if (stop_end && wlen != 2'd0 && !nack_q) begin
         nv_q <= NVW'(NV_CYCLES);
      end else if (nv_q != '0) begin
         nv_q <= nv_q - NVW'(1);
      end
   end

   // ----------------------------------------
   // two-wire master engine
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= HM_IDLE;
         q_cnt_q <= '0;
         phase_q <= 2'd0;
         bitn_q <= 4'h0;
         sh_q <= 8'h00;
         ackbit_q <= 1'b0;
         rd_phase_q <= 1'b0;
         cnt_q <= 2'd0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         nack_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         q_cnt_q <= (tick || !busy) ? '0 : q_cnt_q + QW'(1);
         if (tick && (state_q == HM_START || state_q == HM_BYTE || state_q == HM_STOP)) begin
            phase_q <= phase_q + 2'd1;
         end
         unique case (state_q)
            HM_IDLE: begin
               if (go) begin
                  // one command per go; each single conversion is its own go
                  nack_q <= 1'b0;
                  rd_phase_q <= 1'b0;
                  cnt_q <= 2'd0;
                  phase_q <= 2'd0;
                  state_q <= (wlen != 2'd0 && nv_q != '0) ? HM_HOLD : HM_START;
               end
            end
            HM_HOLD: begin
               if (nv_q == '0) begin
                  state_q <= HM_START;
               end
            end
            HM_START: begin
               if (tick) begin
                  unique case (phase_q)
                     2'd0: sda_oe_q <= 1'b0;
                     2'd1: scl_oe_q <= 1'b0;
                     2'd2: sda_oe_q <= 1'b1;
                     2'd3: begin
                        scl_oe_q <= 1'b1;
                        sh_q <= addr_byte;
                        bitn_q <= 4'h0;
                        state_q <= HM_BYTE;
                     end
                  endcase
               end
            end
            HM_BYTE: begin
               if (tick) begin
                  unique case (phase_q)
                     2'd0: sda_oe_q <= (bitn_q == 4'd8) ? (is_rx & ~last_rx) : (~is_rx & ~sh_q[7]);
                     2'd1: scl_oe_q <= 1'b0;
                     2'd2: begin
                        if (bitn_q == 4'd8) begin
                           ackbit_q <= link.sda;
                        end else begin
                           sh_q <= {sh_q[6:0], link.sda};
                        end
                     end
                     2'd3: begin
                        scl_oe_q <= 1'b1;
                        bitn_q <= bitn_q + 4'h1;
                        if (bitn_q == 4'd8) begin
                           bitn_q <= 4'h0;
                           if (!is_rx && ackbit_q) begin
                              nack_q <= 1'b1;
                              state_q <= HM_STOP;
                           end else if (is_rx) begin
                              rdata_q <= {rdata_q[7:0], sh_q};
                              if (last_rx) begin
                                 state_q <= HM_STOP;
                              end else begin
                                 cnt_q <= cnt_inc;
                              end
                           end else if (rd_phase_q) begin
                              cnt_q <= 2'd1;
                           end else if (more_tx) begin
                              sh_q <= next_tx;
                              cnt_q <= cnt_inc;
                           end else if (rlen != 2'd0) begin
                              rd_phase_q <= 1'b1;
                              cnt_q <= 2'd0;
                              state_q <= HM_START;
                           end else begin
                              state_q <= HM_STOP;
                           end
                        end
                     end
                  endcase
               end
            end
            HM_STOP: begin
               if (tick) begin
                  unique case (phase_q)
                     2'd0: sda_oe_q <= 1'b1;
                     2'd1: scl_oe_q <= 1'b0;
                     2'd2: sda_oe_q <= 1'b0;
                     2'd3: state_q <= HM_IDLE;
                  endcase
               end
            end
         endcase
      end
   end

   assign wb_ack_out = ack_q;
   assign wb_dat_out = dat_q;
   assign link.m_scl_out = 1'b0;
   assign link.m_scl_oe = scl_oe_q;
   assign link.m_sda_out = 1'b0;
   assign link.m_sda_oe = sda_oe_q;

endmodule // therm_master

// ==== bench/therm_link_properties.sv ====
`timescale 1ns/1ps
module therm_link_properties (
   input logic ref_clk_in,
   input logic rst_in,
   input logic m_scl_out,
   input logic m_scl_oe,
   input logic m_sda_out,
   input logic m_sda_oe,
   input logic s_sda_out,
   input logic s_sda_oe,
   input logic scl,
   input logic sda
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   sequence scl_hi8; scl [*8]; endsequence
   sequence scl_lo8; !scl [*8]; endsequence
   open_drain_a: assert property (!m_scl_out && !m_sda_out && !s_sda_out)
      else $error("open drain value not low");
   slave_drive_a: assert property ($rose(s_sda_oe) |-> !scl) else $error("slave pulled sda with scl high");
   slave_release_a: assert property ($fell(s_sda_oe) |-> !scl) else $error("slave let go with scl high");
   ack_hold_a: assert property (s_sda_oe && $rose(scl) |-> s_sda_oe [*8]) else $error("slave bit not held");
   stop_idle_a: assert property ($rose(sda) && scl |=> (scl && sda) [*8]) else $error("bus not idle");
   start_hold_a: assert property ($fell(sda) && scl |=> scl_hi8) else $error("start too short");
   scl_low_a: assert property ($fell(scl) |-> scl_lo8) else $error("scl low too short");
   bus_turn_a: assert property (s_sda_oe && scl |-> !m_sda_oe && !m_scl_oe) else $error("both drive sda");
endmodule // therm_link_properties

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
   import therm_pkg::*;
   logic ref_clk_in = 0;
   logic rst_in = 1;
   logic wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0, done = 0, alarm = 1;
   logic [3:0] wb_adr_in = 4'h0;
   logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rd;
   logic wb_ack_out, conv_start_out, converting_out, single_out, pol_out, thermo_out;
   logic [2:0] sel = 3'h0;
   logic [7:0] cnt = 8'h0;
   logic [15:0] hi, val = 16'h0;
   logic [31:0] exp_q[$];
   int n_mismatch = 0, tests_run = 0, n_start = 0;
   therm_link_if link();
   therm_master #(.NV_CYCLES(50)) i_therm_master(.ref_clk_in(ref_clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
      .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(4'hf), .wb_dat_in(wb_dat_in),
      .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .link(link));
   therm_slave #(.NV_CYCLES(50)) i_therm_slave(.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(link),
      .addr_sel_in(sel), .temperature_in(val), .count_remaining_in(cnt), .slope_in(~cnt), .conv_done_in(done),
      .alarm_in(alarm), .conv_start_out(conv_start_out), .converting_out(converting_out), .high_threshold_out(hi),
      .low_threshold_out(), .single_conversion_select_out(single_out), .output_polarity_out(pol_out),
      .nonvolatile_busy_out(), .thermostat_output_out(thermo_out));
   therm_link_properties i_props(.ref_clk_in(ref_clk_in), .rst_in(rst_in), .m_scl_out(link.m_scl_out),
      .m_scl_oe(link.m_scl_oe), .m_sda_out(link.m_sda_out), .m_sda_oe(link.m_sda_oe), .s_sda_out(link.s_sda_out),
      .s_sda_oe(link.s_sda_oe), .scl(link.scl), .sda(link.sda));
   initial forever #5 ref_clk_in = ~ref_clk_in;
   // ----------------------------------------
   // checking and bus tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, want, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      int i;
      @(posedge ref_clk_in);
      wb_cyc_in <= 1;
      wb_stb_in <= 1;
      wb_we_in <= we;
      wb_adr_in <= a;
      wb_dat_in <= d;
      i = 0;
      do @(posedge ref_clk_in); while (wb_ack_out !== 1'b1 && ++i < 20);
      rd = wb_dat_out;
      wb_cyc_in <= 0;
      wb_stb_in <= 0;
      if (i >= 20) begin
         n_mismatch++;
         complete_run();
      end
   endtask
   // one controller order, then poll until idle
   task automatic go(input logic [7:0] cmd, input logic [1:0] wl, input logic [1:0] rl, input logic [15:0] wd);
      int i;
      wb(1, REG_WDATA, {16'h0, wd});
      wb(1, REG_CTRL, {16'h0, sel, rl, wl, 1'b1, cmd});
      i = 0;
      do wb(0, REG_STATUS, 32'h0); while (rd[STAT_BUSY_BIT] === 1'b1 && ++i < 30000);
      if (i >= 30000) begin
         n_mismatch++;
         complete_run();
      end
   endtask
   always @(posedge ref_clk_in) begin
      if (conv_start_out === 1'b1) n_start <= n_start + 1;
      if (wb_ack_out === 1'b1 && !wb_we_in && wb_adr_in == REG_RDATA && exp_q.size() > 0)
         chk("rdata", wb_dat_out, exp_q.pop_front());
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(27514));
      sel = 3'($urandom);
      val = 16'($urandom);
      cnt = 8'($urandom);
      repeat (10) @(posedge ref_clk_in);
      rst_in <= 0;
      go(CMD_CONFIG, 2'd1, 2'd0, 16'h0200);
      chk("single", single_out, 0);
      chk("polarity", pol_out, 1);
      chk("thermostat", thermo_out, alarm);
      go(CMD_HIGH, 2'd2, 2'd0, val);
      chk("high", hi, val);
      go(CMD_START, 2'd0, 2'd0, 16'h0);
      chk("starts", n_start, 1);
      @(posedge ref_clk_in) done <= 1;
      @(posedge ref_clk_in) done <= 0;
      repeat (3) @(posedge ref_clk_in);
      chk("restart", n_start, 2);
      chk("converting", converting_out, 1);
      exp_q.push_back({24'h0, cnt});
      go(CMD_COUNT, 2'd0, 2'd1, 16'h0);
      wb(0, REG_RDATA, 32'h0);
      @(posedge ref_clk_in);
      chk("pending", exp_q.size(), 0);
      complete_run();
   end
endmodule // tb
